// *** iacs_accum.sv ***
// averaging accumulator for the elementary conversion results
`timescale 1ns/1ps
`default_nettype none
module iacs_accum #(
    parameter int SW = 16
) (
    input  wire logic          sys_clk_in,
    input  wire logic          reset_in,
    input  wire logic          clear_in,
    input  wire logic          add_in,
    input  wire logic [SW-1:0] sample_in,
    input  wire logic [1:0]    shift_in,
    output logic [SW-1:0]      mean_out
);
    initial begin
        if (SW < 2) $error("iacs_accum: width too small");
    end

    logic [SW+2:0] sum_r;
    logic [SW+2:0] sum_nxt;
    logic [SW-1:0] mean_nxt;

    always_comb begin
        sum_nxt = sum_r;
        if (clear_in) begin
            sum_nxt = '0;
        end else if (add_in) begin
            sum_nxt = sum_r + {3'h0, sample_in};
        end
        // count is a power of two, so the mean is a shift
        mean_nxt = SW'(sum_r >> shift_in);
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sum_r    <= '0;
            mean_out <= '0;
        end else begin
            sum_r    <= sum_nxt;
            mean_out <= mean_nxt;
        end
    end
endmodule // iacs_accum
`default_nettype wire

// *** iacs_pkg.sv ***
// package for the incremental converter sequencer: layout, reset values, timing
package iacs_pkg;

    // register byte offsets on the plain register port (index = byte address / 4)
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] CFG_OFF    = 8'h04;
    localparam logic [7:0] GAIN_OFF   = 8'h08;
    localparam logic [7:0] OFFS_OFF   = 8'h0c;
    localparam logic [7:0] STAT_OFF   = 8'h10;
    localparam logic [7:0] RESULT_OFF = 8'h14;
    localparam logic [7:0] SAMPLE_OFF = 8'h18;

    // control bits (write-only pulses)
    localparam int START_BIT = 0;
    localparam int DEF_BIT   = 1;

    // configuration field positions
    localparam int FS_LSB    = 0;
    localparam int RATIO_LSB = 2;
    localparam int COUNT_LSB = 5;

    // reset and default values
    localparam logic [1:0] FS_RST    = 2'h3;
    localparam logic [2:0] RATIO_RST = 3'h2;
    localparam logic [1:0] COUNT_RST = 2'h1;
    localparam logic [6:0] GAIN_RST  = 7'h0c;
    localparam logic [6:0] OFFS_RST  = 7'h00;

    // ratio exponent base: ratio = 2^(RATIO_BASE + setting)
    localparam int RATIO_BASE = 3;

    // oscillator and sampling-rate divider timing
    localparam int CLK_MHZ = 250;
    localparam int OSC_KHZ = 4000;
    localparam int OSC_DIV = CLK_MHZ * 1000 / OSC_KHZ;
    localparam int FS_BASE_DIV = 64;

    // setup and wrap-up sampling periods around a conversion
    localparam int INIT_PERIODS = 2;
    localparam int END_PERIODS  = 2;

    // msb first, so the fields land on the *_LSB positions above
    typedef struct packed {
        logic [1:0] count_setting_field;
        logic [2:0] ratio_setting_field;
        logic [1:0] fs;
    } iacs_cfg_t;

    typedef struct packed {
        logic       neg;
        logic [5:0] mag;
    } iacs_offs_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_INIT  = 5'b00010,
        ST_ELEM  = 5'b00100,
        ST_QUANT = 5'b01000,
        ST_END   = 5'b10000
    } iacs_state_t;

endpackage : iacs_pkg

// *** iacs_seq.sv ***
// conversion sequencer with register port, third-stage code decode and averaging
//
// Notes on behaviour
// R1 - start or defaults bit launches a conversion
// R2 - counted elementary conversions then one quantization
// R3 - each elementary lasts ratio plus one periods
// R4 - result is mean of elementary results
// R5 - offset polarity alternates between elementary conversions
// R6 - software should program count of two or more
// R7 - extra periods before and after conversion
// R8 - gain code is twelfths, seven bits unsigned
// R9 - offset code sign-magnitude, zero magnitude means zero
// R10 - rate, ratio and count set performance
// R11 - ratio is two to three plus setting
// R12 - count is two to the setting
// R13 - busy reads one while converting
// R14 - defaults restore config and restart immediately
// R15 - result and busy change after quantization
`timescale 1ns/1ps
`default_nettype none
module iacs_seq #(
    parameter int SW = 16
) (
    input  wire logic          sys_clk_in,
    input  wire logic          reset_in,
    input  wire logic [7:0]    addr_in,
    input  wire logic [31:0]   wdata_in,
    input  wire logic          wr_in,
    input  wire logic          rd_in,
    output logic [31:0]        rdata_out,
    input  wire logic [SW-1:0] sample_in,
    output logic               busy_out,
    output logic               offset_polarity_out,
    output logic               integrate_out,
    output logic               quantize_out,
    output logic               result_valid_out,
    output logic [6:0]         gain_twelfths_out,
    output logic signed [7:0]  offset_twelfths_out
);
    initial begin
        if (SW < 2 || SW > 29) $error("iacs_seq: sample width out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [10:0] ratio_of(input logic [2:0] s);
        ratio_of = 11'(1) << (iacs_pkg::RATIO_BASE + int'(s)); // R11
    endfunction

    function automatic logic [3:0] count_of(input logic [1:0] s);
        count_of = 4'(1) << s; // R12
    endfunction

    function automatic logic signed [7:0] offs_of(input iacs_pkg::iacs_offs_t o);
        // negative zero decodes to zero
        offs_of = o.neg ? -$signed({2'b00, o.mag}) : $signed({2'b00, o.mag}); // R9
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    iacs_pkg::iacs_cfg_t  cfg_r, cfg_nxt;
    logic [6:0]           gain_r, gain_nxt;
    iacs_pkg::iacs_offs_t offs_r, offs_nxt;
    logic [SW-1:0]        sample_r;
    logic [SW-1:0]        sample_sync_r;
    logic [SW-1:0]        result_r, result_nxt;
    logic [31:0]          rdata_nxt;
    logic                 start_req;
    logic                 def_req;
    logic                 launch;

    assign start_req = wr_in && addr_in == iacs_pkg::CTRL_OFF
                       && wdata_in[iacs_pkg::START_BIT];
    assign def_req   = wr_in && addr_in == iacs_pkg::CTRL_OFF
                       && wdata_in[iacs_pkg::DEF_BIT];
    assign launch    = start_req || def_req; // R1

    always_comb begin
        cfg_nxt  = cfg_r;
        gain_nxt = gain_r;
        offs_nxt = offs_r;
        if (def_req) begin // R14
            cfg_nxt  = '{fs: iacs_pkg::FS_RST, ratio_setting_field: iacs_pkg::RATIO_RST,
                         count_setting_field: iacs_pkg::COUNT_RST};
            gain_nxt = iacs_pkg::GAIN_RST;
            offs_nxt = iacs_pkg::OFFS_RST;
        end else if (wr_in) begin
            unique case (addr_in)
                iacs_pkg::CFG_OFF:  cfg_nxt  = wdata_in[6:0];
                iacs_pkg::GAIN_OFF: gain_nxt = wdata_in[6:0]; // R8
                iacs_pkg::OFFS_OFF: offs_nxt = wdata_in[6:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    iacs_pkg::iacs_state_t st_r, st_nxt;
    logic [10:0] per_r, per_nxt;
    logic [3:0]  elem_r, elem_nxt;
    logic        pol_r, pol_nxt;
    logic        tick;
    logic        acc_clear;
    logic        acc_add;
    logic [SW-1:0] mean;

    iacs_tick u_tick (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .restart_in (launch),
        .fs_in      (cfg_r.fs), // R10
        .tick_out   (tick)
    );

    iacs_accum #(.SW(SW)) u_accum (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .clear_in   (acc_clear),
        .add_in     (acc_add),
        .sample_in  (sample_sync_r),
        .shift_in   (cfg_r.count_setting_field),
        .mean_out   (mean)
    );

    always_comb begin
        st_nxt     = st_r;
        per_nxt    = per_r;
        elem_nxt   = elem_r;
        pol_nxt    = pol_r;
        acc_clear  = 1'b0;
        acc_add    = 1'b0;
        result_nxt = result_r;
        if (launch) begin // R14
            st_nxt    = iacs_pkg::ST_INIT;
            per_nxt   = '0;
            elem_nxt  = '0;
            pol_nxt   = 1'b0;
            acc_clear = 1'b1;
        end else if (tick) begin
            unique case (st_r)
                iacs_pkg::ST_IDLE: ;
                iacs_pkg::ST_INIT: begin // R7
                    per_nxt = per_r + 1'b1;
                    if (per_r == 11'(iacs_pkg::INIT_PERIODS - 1)) begin
                        st_nxt  = iacs_pkg::ST_ELEM;
                        per_nxt = '0;
                    end
                end
                iacs_pkg::ST_ELEM: begin
                    per_nxt = per_r + 1'b1;
                    if (per_r == ratio_of(cfg_r.ratio_setting_field)) begin // R3
                        per_nxt  = '0;
                        acc_add  = 1'b1;
                        pol_nxt  = ~pol_r; // R5
                        elem_nxt = elem_r + 1'b1;
                        if (elem_r == count_of(cfg_r.count_setting_field) - 4'h1) begin
                            st_nxt = iacs_pkg::ST_QUANT; // R2
                        end
                    end
                end
                iacs_pkg::ST_QUANT: begin
                    st_nxt = iacs_pkg::ST_END;
                end
                iacs_pkg::ST_END: begin // R7
                    per_nxt = per_r + 1'b1;
                    if (per_r == 11'(iacs_pkg::END_PERIODS - 1)) begin
                        st_nxt     = iacs_pkg::ST_IDLE;
                        per_nxt    = '0;
                        result_nxt = mean; // R4 R15
                    end
                end
                default: st_nxt = iacs_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        rdata_nxt = '0;
        if (rd_in) begin
            unique case (addr_in)
                iacs_pkg::CFG_OFF:    rdata_nxt = {25'h0, cfg_r};
                iacs_pkg::GAIN_OFF:   rdata_nxt = {25'h0, gain_r};
                iacs_pkg::OFFS_OFF:   rdata_nxt = {25'h0, offs_r};
                iacs_pkg::STAT_OFF:   rdata_nxt = {27'h0, st_r != iacs_pkg::ST_IDLE,
                                                   elem_r}; // R13
                iacs_pkg::RESULT_OFF: rdata_nxt = 32'(result_r);
                default:              rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_r      <= '{fs: iacs_pkg::FS_RST, ratio_setting_field: iacs_pkg::RATIO_RST,
                            count_setting_field: iacs_pkg::COUNT_RST};
            gain_r     <= iacs_pkg::GAIN_RST;
            offs_r     <= iacs_pkg::OFFS_RST;
            st_r       <= iacs_pkg::ST_IDLE;
            per_r      <= '0;
            elem_r     <= '0;
            pol_r      <= 1'b0;
            result_r   <= '0;
            rdata_out  <= '0;
            sample_r   <= '0;
            sample_sync_r <= '0;
            busy_out   <= 1'b0;
            offset_polarity_out <= 1'b0;
            integrate_out       <= 1'b0;
            quantize_out        <= 1'b0;
            result_valid_out    <= 1'b0;
            gain_twelfths_out   <= '0;
            offset_twelfths_out <= '0;
        end else begin
            cfg_r      <= cfg_nxt;
            gain_r     <= gain_nxt;
            offs_r     <= offs_nxt;
            st_r       <= st_nxt;
            per_r      <= per_nxt;
            elem_r     <= elem_nxt;
            pol_r      <= pol_nxt;
            result_r   <= result_nxt;
            rdata_out  <= rdata_nxt;
            // analog side sample comes from outside this domain
            sample_r      <= sample_in;
            sample_sync_r <= sample_r;
            busy_out   <= st_nxt != iacs_pkg::ST_IDLE; // R13
            offset_polarity_out <= pol_nxt; // R5
            integrate_out       <= st_nxt == iacs_pkg::ST_ELEM;
            quantize_out        <= st_nxt == iacs_pkg::ST_QUANT;
            result_valid_out    <= result_nxt != result_r
                                   || (tick && st_r == iacs_pkg::ST_END
                                       && st_nxt == iacs_pkg::ST_IDLE);
            gain_twelfths_out   <= gain_nxt; // R8
            offset_twelfths_out <= offs_of(offs_nxt); // R9
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // phase ends, as named sequences
    sequence s_init_last;
        tick && !launch && st_r == iacs_pkg::ST_INIT
        && per_r == 11'(iacs_pkg::INIT_PERIODS - 1);
    endsequence

    sequence s_elem_last;
        acc_add && elem_r == count_of(cfg_r.count_setting_field) - 4'h1;
    endsequence

    sequence s_quant_step;
        tick && !launch && st_r == iacs_pkg::ST_QUANT;
    endsequence

    sequence s_end_last;
        tick && !launch && st_r == iacs_pkg::ST_END
        && per_r == 11'(iacs_pkg::END_PERIODS - 1);
    endsequence

    a_busy_follows_state: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R13
        busy_out == (st_r != iacs_pkg::ST_IDLE))
        else $error("busy mismatch");
    a_launch_goes_busy: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R1
        launch |=> busy_out && st_r == iacs_pkg::ST_INIT)
        else $error("no launch");
    a_def_restores: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R14
        def_req |=> cfg_r.ratio_setting_field == iacs_pkg::RATIO_RST)
        else $error("defaults not loaded");
    a_polarity_flips: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R5
        acc_add && !launch |=> offset_polarity_out != $past(offset_polarity_out))
        else $error("polarity stuck");
    a_elem_length: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R3
        acc_add |-> per_r == ratio_of(cfg_r.ratio_setting_field))
        else $error("bad elementary length");
    a_quant_after_count: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R2
        st_r == iacs_pkg::ST_ELEM && st_nxt == iacs_pkg::ST_QUANT
        |-> elem_nxt == count_of(cfg_r.count_setting_field))
        else $error("bad count");
    a_result_at_end: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R15
        result_r != $past(result_r) |-> $past(st_r) == iacs_pkg::ST_END && !busy_out)
        else $error("result early");
    a_offset_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R9
        offs_r.mag == 6'h00 |=> offset_twelfths_out == 8'sh00 || $changed(offs_r))
        else $error("negative zero");
    a_init_to_elem: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R7 R5
        s_init_last |=> integrate_out && !offset_polarity_out)
        else $error("init phase length");
    a_last_to_quant: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R2
        s_elem_last |=> quantize_out && !integrate_out)
        else $error("no quantization step");
    a_quant_one_period: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R2
        s_quant_step |=> st_r == iacs_pkg::ST_END && !quantize_out)
        else $error("quantization too long");
    a_end_clears_busy: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R15
        s_end_last |=> !busy_out && result_valid_out)
        else $error("end phase length");
    a_valid_one_cycle: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R15
        result_valid_out |=> !result_valid_out)
        else $error("valid pulse too long");
    a_offset_negative: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R9
        offs_r.neg && offs_r.mag != 6'h00 |=> offset_twelfths_out < 8'sh00 || $changed(offs_r))
        else $error("negative offset lost");
endmodule // iacs_seq
`default_nettype wire

// *** iacs_seq_tb_top.sv ***
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module iacs_seq_tb_top;
    localparam int TBASE = iacs_pkg::FS_BASE_DIV * iacs_pkg::OSC_DIV;
    localparam int INI   = iacs_pkg::INIT_PERIODS;
    localparam int FIN   = iacs_pkg::END_PERIODS;
    logic               sys_clk_in;
    logic               reset_in;
    logic [7:0]         addr_in;
    logic [31:0]        wdata_in;
    logic               wr_in;
    logic               rd_in;
    logic [31:0]        rdata_out;
    logic [15:0]        sample_in;
    logic               busy_out;
    logic               offset_polarity_out;
    logic               integrate_out;
    logic               quantize_out;
    logic               result_valid_out;
    logic [6:0]         gain_twelfths_out;
    logic [7:0]         offset_twelfths_out;
    int                 failures;
    int                 n_checks;
    int                 valid_seen;
    int                 conv_t;
    logic [31:0]        rv;

    iacs_seq #(.SW(16)) dut (
        .sys_clk_in          (sys_clk_in),
        .reset_in            (reset_in),
        .addr_in             (addr_in),
        .wdata_in            (wdata_in),
        .wr_in               (wr_in),
        .rd_in               (rd_in),
        .rdata_out           (rdata_out),
        .sample_in           (sample_in),
        .busy_out            (busy_out),
        .offset_polarity_out (offset_polarity_out),
        .integrate_out       (integrate_out),
        .quantize_out        (quantize_out),
        .result_valid_out    (result_valid_out),
        .gain_twelfths_out   (gain_twelfths_out),
        .offset_twelfths_out (offset_twelfths_out)
    );

    always #2 sys_clk_in = ~sys_clk_in;

    always @(posedge sys_clk_in) begin
        if (result_valid_out === 1'b1) valid_seen <= valid_seen + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic advance_to(input int t);
        while (conv_t < t) begin
            @(posedge sys_clk_in);
            conv_t++;
        end
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // probes each phase after the init phase at its midpoint, so edge skew of a cycle is harmless
    task automatic run_conv(input logic [2:0] r, input logic [1:0] c,
                            input logic [15:0] smp, input logic [15:0] old,
                            input logic [1:0] f);
        int   oversampling_ratio;
        int   n;
        int   tk;
        int   te;
        int   v0;
        logic pp;
        oversampling_ratio = 1 << (3 + r);
        n   = 1 << c;
        tk  = TBASE >> f;
        te  = (INI + n * (oversampling_ratio + 1) + 1 + FIN) * tk;
        pp  = 1'b0;
        bus_wr(iacs_pkg::CFG_OFF, {25'h0, c, r, f});
        sample_in <= smp;
        v0 = valid_seen;
        bus_wr(iacs_pkg::CTRL_OFF, 32'h1);
        conv_t = 0;
        for (int k = 0; k < n; k++) begin
            advance_to((INI + k * (oversampling_ratio + 1)) * tk + (oversampling_ratio + 1) * tk / 2);
            check(integrate_out, 1'b1);
            check(busy_out, 1'b1);
            if (k > 0) check(offset_polarity_out, !pp);
            pp = offset_polarity_out;
        end
        advance_to((INI + n * (oversampling_ratio + 1)) * tk + tk / 2);
        check(quantize_out, 1'b1);
        check(integrate_out, 1'b0);
        advance_to((INI + n * (oversampling_ratio + 1) + 1) * tk + tk);
        check(busy_out, 1'b1);
        bus_rd(iacs_pkg::RESULT_OFF, rv);
        conv_t += 2;
        check(rv, {16'h0, old});
        while (busy_out === 1'b1 && conv_t < te + 8) begin
            @(posedge sys_clk_in);
            #1;
            conv_t++;
        end
        if (busy_out !== 1'b0) begin
            failures++;
            print_verdict();
        end
        check(conv_t >= te - 3 && conv_t <= te + 3, 1'b1);
        repeat (3) @(posedge sys_clk_in);
        check(valid_seen - v0, 1);
        bus_rd(iacs_pkg::RESULT_OFF, rv);
        check(rv, {16'h0, smp});
        bus_rd(iacs_pkg::STAT_OFF, rv);
        check(rv[4], 1'b0);
        $display("test conversion ratio %0d count %0d done", oversampling_ratio, n);
    endtask

    ////////////////////////////////////////////////////////////////////////
    logic [6:0] gains [4] = '{7'h00, 7'h01, 7'h0c, 7'h7f};
    logic [6:0] offs  [6] = '{7'h00, 7'h01, 7'h3f, 7'h40, 7'h41, 7'h7f};
    logic [7:0] offx  [6] = '{8'h00, 8'h01, 8'h3f, 8'h00, 8'hff, 8'hc1};

    initial begin
        sys_clk_in = 1'b0;
        reset_in   = 1'b1;
        addr_in    = 8'h00;
        wdata_in   = 32'h0;
        wr_in      = 1'b0;
        rd_in      = 1'b0;
        sample_in  = 16'h0;
        failures   = 0;
        n_checks   = 0;
        valid_seen = 0;
        conv_t     = 0;
        repeat (2) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        bus_rd(iacs_pkg::CFG_OFF, rv);
        check(rv, 32'h2b);
        bus_rd(iacs_pkg::GAIN_OFF, rv);
        check(rv, 32'h0c);
        bus_rd(iacs_pkg::OFFS_OFF, rv);
        check(rv, 32'h0);
        bus_rd(iacs_pkg::STAT_OFF, rv);
        check(rv[4], 1'b0);
        bus_wr(8'hfc, 32'hffff_ffff);
        bus_rd(8'hfc, rv);
        check(rv, 32'h0);
        $display("test reset values done");
        foreach (gains[i]) begin
            bus_wr(iacs_pkg::GAIN_OFF, {25'h0, gains[i]});
            repeat (2) @(posedge sys_clk_in);
            check(gain_twelfths_out, gains[i]);
            bus_rd(iacs_pkg::GAIN_OFF, rv);
            check(rv, {25'h0, gains[i]});
        end
        foreach (offs[i]) begin
            bus_wr(iacs_pkg::OFFS_OFF, {25'h0, offs[i]});
            repeat (2) @(posedge sys_clk_in);
            check(offset_twelfths_out, offx[i]);
        end
        $display("test code decode done");
        run_conv(3'h0, 2'h0, 16'h1234, 16'h0000, 2'h2);
        run_conv(3'h0, 2'h1, 16'hbeef, 16'h1234, 2'h3);
        run_conv(3'h0, 2'h2, 16'h00a5, 16'hbeef, 2'h3);
        run_conv(3'h1, 2'h0, 16'h7fff, 16'h00a5, 2'h3);
        // defaults in mid-conversion: old run must never finish
        bus_wr(iacs_pkg::CFG_OFF, {25'h0, 2'h0, 3'h0, 2'h3});
        bus_wr(iacs_pkg::CTRL_OFF, 32'h1);
        conv_t = 0;
        advance_to(10 * (TBASE >> 3));
        bus_wr(iacs_pkg::CTRL_OFF, 32'h2);
        @(posedge sys_clk_in);
        #1 check(busy_out, 1'b1);
        bus_rd(iacs_pkg::CFG_OFF, rv);
        check(rv, 32'h2b);
        bus_rd(iacs_pkg::GAIN_OFF, rv);
        check(rv, 32'h0c);
        check(offset_twelfths_out, 8'h00);
        conv_t = 0;
        rv = valid_seen;
        advance_to(6 * (TBASE >> 3));
        check(busy_out, 1'b1);
        check(valid_seen, rv);
        $display("test defaults restart done");
        run_conv(3'h0, 2'h1, 16'h0f0f, 16'h7fff, 2'h3);
        print_verdict();
    end
endmodule // iacs_seq_tb_top
`default_nettype wire

// *** iacs_tick.sv ***
// oversampling tick generator derived from the internal oscillator rate
`timescale 1ns/1ps
`default_nettype none
module iacs_tick #(
    parameter int OSC_DIV     = iacs_pkg::OSC_DIV,
    parameter int FS_BASE_DIV = iacs_pkg::FS_BASE_DIV
) (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_in,
    input  wire logic       restart_in,
    input  wire logic [1:0] fs_in,
    output logic            tick_out
);
    localparam int MAXDIV = OSC_DIV * FS_BASE_DIV;
    localparam int CW     = $clog2(MAXDIV + 1);

    initial begin
        if (OSC_DIV < 1 || FS_BASE_DIV < 8) $error("iacs_tick: bad divider");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [CW-1:0] top;
    logic          tick_nxt;

    always_comb begin
        // fs setting 3 is the fastest rate, each step down halves it
        top      = CW'((MAXDIV >> fs_in) - 1);
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + 1'b1;
        if (restart_in) begin
            cnt_nxt = '0;
        end else if (cnt_r >= top) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_r    <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            tick_out <= tick_nxt;
        end
    end
endmodule // iacs_tick
`default_nettype wire
